// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cod_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic start_i = 1'b0, prefix_i = 1'b0, load_i = 1'b0, bad;
    cod_cmd_t cmd_i = CMD_EXEC;
    cod_mode_t mode_i = MD_INH;
    cod_move_t move_i = MV_DD;
    logic [7:0] opcode_i = 8'h00, l_a = 8'h00, l_x = 8'h00, l_h = 8'h00, l_f = 8'h00;
    logic [15:0] l_sp = 16'h0000, l_pc = 16'h0000;
    logic [7:0] mem [0:65535];
    logic [15:0] mem_addr_o, sp_o, pc_o, ea_o, target_o;
    logic mem_rd_o, mem_wr_o, busy_o, done_o, bad_op_o;
    logic [7:0] mem_wdata_o, acc_o, idx_lo_o, idx_hi_o, flags_o, operand_o;
    int miscompares = 0;
    int n_compared = 0;
    int n_rd = 0;
    cod_mode_t fm [10] = '{MD_EXT, MD_IX2, MD_IX1, MD_IX1P, MD_SP1, MD_SP2, MD_IX, MD_IXP,
        MD_DIR, MD_DIRREL};
    logic [15:0] fe [10] = '{16'h1280, 16'h2280, 16'h1012, 16'h1012, 16'h0112, 16'h1380,
        16'h1000, 16'h1000, 16'h0012, 16'h0012};
    logic [3:0] fn [10] = '{4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h4, 4'h2, 4'h2, 4'h3, 4'h4};

    cod_core cod_core_i (.clk_i, .nrst_i, .start_i, .cmd_i, .opcode_i, .prefix_i, .mode_i,
        .move_i, .load_i, .load_acc_i(l_a), .load_idx_lo_i(l_x), .load_idx_hi_i(l_h),
        .load_sp_i(l_sp), .load_pc_i(l_pc), .load_flags_i(l_f),
        .mem_rdata_i(mem[mem_addr_o]), .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o,
        .acc_o, .idx_lo_o, .idx_hi_o, .sp_o, .pc_o, .flags_o, .busy_o, .done_o, .bad_op_o,
        .operand_o, .ea_o, .target_o);

    always #12.5 clk_i = ~clk_i;

    // Memory answers in the same cycle, as the core expects
    always @(posedge clk_i) begin
        n_rd += int'(mem_rd_o === 1'b1);
        if (mem_wr_o === 1'b1) begin
            mem[mem_addr_o] <= mem_wdata_o;
        end
    end

    task automatic print_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic ld(input logic [7:0] a, x, h, f, input logic [15:0] sp, pc);
        @(negedge clk_i);
        {l_a, l_x, l_h, l_f, l_sp, l_pc} = {a, x, h, f, sp, pc};
        load_i = 1'b1;
        @(negedge clk_i);
        load_i = 1'b0;
    endtask

    // Counts busy cycles up to done; the bound keeps a stuck core from hanging here
    task automatic run(input cod_cmd_t c, input logic [7:0] op, input logic pf,
        input logic [3:0] n, input cod_mode_t md = MD_INH, input cod_move_t mv = MV_DD);
        int nc;
        @(negedge clk_i);
        cmd_i = c;
        opcode_i = op;
        prefix_i = pf;
        mode_i = md;
        move_i = mv;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        nc = 0;
        for (int k = 0; k < 40 && done_o !== 1'b1; k++) begin
            nc += int'(busy_o === 1'b1);
            @(negedge clk_i);
        end
        bad = bad_op_o;
        chk("cycles", {12'h000, n}, 16'(nc));
    endtask

    task automatic tst(input logic [7:0] op, input logic pf, input logic [3:0] n,
        input logic [7:0] fx, ox);
        ld(8'h80, 8'h00, 8'h01, 8'h80, 16'h01F0, 16'h0200);
        run(CMD_EXEC, op, pf, n);
        chk("test flags", {8'h00, fx}, {8'h00, flags_o & 8'h86});
        chk("test operand", {8'h00, ox}, {8'h00, operand_o});
        chk("test acc", 16'h0080, {8'h00, acc_o});
    endtask

    task automatic mv(input cod_move_t k, input logic [15:0] s, d, input logic [3:0] n,
        input logic [15:0] hx);
        logic [7:0] e;
        e = mem[s];
        mem[d] = ~e;
        ld(8'h00, 8'h00, 8'h10, 8'h00, 16'h0100, 16'h0300);
        run(CMD_MOVE, 8'h00, 1'b0, n, MD_INH, k);
        chk("moved byte", {8'h00, e}, {8'h00, mem[d]});
        chk("move index", hx, {idx_hi_o, idx_lo_o});
    endtask

    initial begin
        repeat (3000) @(posedge clk_i);
        miscompares++;
        print_verdict();
    end

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
        end
        repeat (16) @(negedge clk_i);
        chk("reset sp", 16'h00FF, sp_o);
        chk("reset flags", 16'h0008, {8'h00, flags_o});
        nrst_i = 1'b1;
        // ----------------------------------------
        // Test for negative or zero
        // ----------------------------------------
        {mem[16'h0201], mem[16'h0202], mem[16'h0040]} = 24'h400500;
        {mem[16'h0140], mem[16'h0100], mem[16'h01F5]} = 24'h7FFF81;
        tst(8'h4D, 1'b0, 4'h1, 8'h04, 8'h80);
        tst(8'h5D, 1'b0, 4'h1, 8'h02, 8'h00);
        tst(8'h3D, 1'b0, 4'h3, 8'h02, 8'h00);
        tst(8'h6D, 1'b0, 4'h3, 8'h00, 8'h7F);
        tst(8'h7D, 1'b0, 4'h2, 8'h04, 8'hFF);
        tst(8'h6D, 1'b1, 4'h4, 8'h04, 8'h81);
        run(CMD_EXEC, 8'h42, 1'b0, 4'h1);
        chk("bad opcode", 16'h0001, {15'h0000, bad});
        // ----------------------------------------
        // Software trap frame and vector
        // ----------------------------------------
        ld(8'h11, 8'h22, 8'h33, 8'h00, 16'h01F0, 16'h0200);
        {mem[16'hFFF0], mem[16'hFFF1]} = 16'hABCD;
        n_rd = 0;
        run(CMD_EXEC, 8'h83, 1'b0, 4'h9);
        chk("trap reads", 16'h0002, 16'(n_rd));
        chk("frame pc", 16'h0102, {mem[16'h01F0], mem[16'h01EF]});
        chk("frame x a", 16'h2211, {mem[16'h01EE], mem[16'h01ED]});
        chk("frame flags", 16'h0000, {8'h00, mem[16'h01EC]});
        chk("trap pc", 16'hABCD, pc_o);
        chk("trap sp mask", 16'hEB08, {sp_o[7:0], flags_o});
        // ----------------------------------------
        // Register transfers
        // ----------------------------------------
        ld(8'h97, 8'h34, 8'h12, 8'h00, 16'h0100, 16'h0200);
        run(CMD_EXEC, 8'h94, 1'b0, 4'h2);
        chk("sp from index", 16'h1233, sp_o);
        run(CMD_EXEC, 8'h95, 1'b0, 4'h2);
        chk("index from sp", 16'h1234, {idx_hi_o, idx_lo_o});
        chk("xfer flags", 16'h0000, {8'h00, flags_o});
        run(CMD_EXEC, 8'h84, 1'b0, 4'h2);
        chk("flags from acc", 16'h0097, {8'h00, flags_o});
        run(CMD_EXEC, 8'h9F, 1'b0, 4'h1);
        chk("acc from x", 16'h0034, {8'h00, acc_o});
        run(CMD_EXEC, 8'h85, 1'b0, 4'h1);
        chk("acc from flags", 16'h9797, {acc_o, flags_o});
        ld(8'h5C, 8'h00, 8'h00, 8'h00, 16'h0100, 16'h0200);
        run(CMD_EXEC, 8'h97, 1'b0, 4'h1);
        chk("x from acc", 16'h5C00, {idx_lo_o, flags_o});
        // ----------------------------------------
        // Operand fetch in every addressing mode
        // ----------------------------------------
        {mem[16'h0301], mem[16'h0302]} = 16'h1280;
        foreach (fm[i]) begin
            ld(8'h00, 8'h00, 8'h10, 8'h00, 16'h0100, 16'h0300);
            run(CMD_FETCH, 8'h00, 1'b0, fn[i], fm[i]);
            chk("fetch ea", fe[i], ea_o);
            chk("fetch operand", {8'h00, mem[fe[i]]}, {8'h00, operand_o});
            chk("fetch index", (fm[i] inside {MD_IX1P, MD_IXP}) ? 16'h1001 : 16'h1000,
                {idx_hi_o, idx_lo_o});
        end
        chk("branch target", 16'h0283, target_o);
        ld(8'h00, 8'h00, 8'h10, 8'h00, 16'h0100, 16'h0300);
        run(CMD_FETCH, 8'h00, 1'b0, 4'h2, MD_IMM);
        chk("literal", 16'h0012, {8'h00, operand_o});
        ld(8'h00, 8'h00, 8'h10, 8'h00, 16'h0100, 16'h0300);
        run(CMD_FETCH, 8'h00, 1'b0, 4'h2, MD_REL);
        chk("rel target", 16'h0314, target_o);
        // ----------------------------------------
        // Memory to memory moves
        // ----------------------------------------
        mv(MV_DD, 16'h0012, 16'h0080, 4'h5, 16'h1000);
        mv(MV_IMD, 16'h0301, 16'h0080, 4'h4, 16'h1000);
        mv(MV_IXPD, 16'h1000, 16'h0012, 4'h4, 16'h1001);
        mv(MV_DIXP, 16'h0012, 16'h1000, 4'h4, 16'h1001);
        print_verdict();
    end
endmodule

// ===== hdl/cod_core.sv
`timescale 1ns/1ps
`include "cod_regs.svh"
// Contract
// - Trap pushes PC, X, A, flags; loads vector
// - Test sets N, Z, clears V, no writeback
// - Test cycle counts depend on addressing mode
// - Index plus 16-bit offset, high byte first
// - Index plus one fetched 8-bit offset
// - Index plus 8-bit offset, then index increments
// - Operand at index, then index increments
// - Direct source to index target, then increment
// - Index source to direct target, increment after read
// - Immediate byte written to direct target
// - Direct source copied to direct target
// - Stack pointer plus 8 or 16-bit offset
// - Extended address fetched high then low
// - Relative offset added to program counter
// - Direct address byte then branch offset byte
// - Immediate operand follows opcode, no address
module cod_core #(
    parameter logic [15:0] VEC_ADDR = `COD_TRAP_VEC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire cod_pkg::cod_cmd_t cmd_i,
    input wire logic [7:0] opcode_i,
    input wire logic prefix_i,
    input wire cod_pkg::cod_mode_t mode_i,
    input wire cod_pkg::cod_move_t move_i,
    input wire logic load_i,
    input wire logic [7:0] load_acc_i,
    input wire logic [7:0] load_idx_lo_i,
    input wire logic [7:0] load_idx_hi_i,
    input wire logic [15:0] load_sp_i,
    input wire logic [15:0] load_pc_i,
    input wire logic [7:0] load_flags_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [15:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    output logic [7:0] acc_o,
    output logic [7:0] idx_lo_o,
    output logic [7:0] idx_hi_o,
    output logic [15:0] sp_o,
    output logic [15:0] pc_o,
    output logic [7:0] flags_o,
    output logic busy_o,
    output logic done_o,
    output logic bad_op_o,
    output logic [7:0] operand_o,
    output logic [15:0] ea_o,
    output logic [15:0] target_o
);
    import cod_pkg::*;

    cod_state_t state_q, state_d;
    cod_op_t op_q, op_d;
    cod_mode_t mode_q, mode_d;
    cod_move_t mv_q, mv_d;
    logic [7:0] opc_q, opc_d, hi_q, hi_d, lo_q, lo_d, rel_q, rel_d;
    logic [7:0] dst_q, dst_d, data_q, data_d, vhi_q, vhi_d;
    logic [3:0] cyc_q, cyc_d, total_q, total_d;
    logic [2:0] push_q, push_d;
    logic [7:0] a_q, a_d, x_q, x_d, h_q, h_d, ccr_q, ccr_d, opnd_q, opnd_d;
    logic [15:0] sp_q, sp_d, pc_q, pc_d, hx_d;
    logic busy_q, busy_d, done_q, done_d, bad_q, bad_d;
    logic [15:0] addr_q, addr_d, ea_q, ea_d, tgt_q, tgt_d;
    logic rd_q, rd_d, wr_q, wr_d;
    logic [7:0] wdata_q, wdata_d, tst_v;
    cod_dec_t dec;
    logic take, last;
    wire [15:0] hx = {h_q, x_q};

    cod_ea_if eai();
    cod_ea u_ea (
        .u(eai.unit)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic cod_dec_t decode(input cod_cmd_t cmd, input logic [7:0] opc,
                                        input logic pfx, input cod_mode_t md,
                                        input cod_move_t mv);
        cod_dec_t d;
        d = '{op: OP_BAD, mode: MD_INH, cycles: 4'h1};
        if (cmd == CMD_FETCH) begin
            d = '{op: OP_FETCH, mode: md, cycles: `COD_CYC_FREE};
        end else if (cmd == CMD_MOVE) begin
            d.op = OP_MOVE;
            d.cycles = `COD_CYC_FREE;
            case (mv)
                MV_IMD: d.mode = MD_IMM;
                MV_IXPD: d.mode = MD_IX;
                default: d.mode = MD_DIR;
            endcase
        end else if (pfx) begin
            if (opc == `COD_OP_TST_IX1) begin
                d = '{op: OP_TEST, mode: MD_SP1, cycles: `COD_CYC_TST_SP1};
            end
        end else begin
            case (opc)
                `COD_OP_TRAP: d = '{op: OP_TRAP, mode: MD_INH, cycles: `COD_CYC_TRAP};
                `COD_OP_TST_DIR: d = '{op: OP_TEST, mode: MD_DIR, cycles: `COD_CYC_TST_DIR};
                `COD_OP_TST_A, `COD_OP_TST_X: begin
                    d = '{op: OP_TEST, mode: MD_INH, cycles: `COD_CYC_TST_INH};
                end
                `COD_OP_TST_IX1: d = '{op: OP_TEST, mode: MD_IX1, cycles: `COD_CYC_TST_IX1};
                `COD_OP_TST_IX: d = '{op: OP_TEST, mode: MD_IX, cycles: `COD_CYC_TST_IX};
                `COD_OP_HX2SP, `COD_OP_SP2HX, `COD_OP_A2F: begin
                    d = '{op: OP_XFER, mode: MD_INH, cycles: `COD_CYC_XFER2};
                end
                `COD_OP_F2A, `COD_OP_A2X, `COD_OP_X2A: begin
                    d = '{op: OP_XFER, mode: MD_INH, cycles: `COD_CYC_XFER1};
                end
                default: d = d;
            endcase
        end
        return d;
    endfunction

    // First step of an operand fetch for a given mode
    function automatic cod_state_t first_step(input cod_mode_t md);
        case (md)
            MD_EXT, MD_IX2, MD_SP2: return ST_OFS_HI;
            MD_DIR, MD_DIRREL, MD_IX1, MD_IX1P, MD_SP1, MD_REL: return ST_OFS_LO;
            MD_INH: return ST_EXEC;
            default: return ST_READ;
        endcase
    endfunction

    assign dec = decode(cmd_i, opcode_i, prefix_i, mode_i, move_i);
    assign take = start_i && (state_q == ST_IDLE);
    assign last = (cyc_q + 4'h1) >= total_q;
    assign tst_v = (mode_q != MD_INH) ? data_q : (opc_q == `COD_OP_TST_A) ? a_q : x_q;

    // ----------------------------------------
    // Sequencer and datapath
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        mode_d = mode_q;
        mv_d = mv_q;
        opc_d = opc_q;
        hi_d = hi_q;
        lo_d = lo_q;
        rel_d = rel_q;
        dst_d = dst_q;
        data_d = data_q;
        vhi_d = vhi_q;
        total_d = total_q;
        push_d = push_q;
        a_d = a_q;
        x_d = x_q;
        h_d = h_q;
        ccr_d = ccr_q;
        sp_d = sp_q;
        pc_d = pc_q;
        opnd_d = opnd_q;
        done_d = 1'b0;
        bad_d = 1'b0;
        hx_d = hx + 16'h1;
        case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    op_d = dec.op;
                    mode_d = dec.mode;
                    mv_d = move_i;
                    opc_d = opcode_i;
                    total_d = dec.cycles;
                    push_d = 3'h0;
                    hi_d = 8'h00;
                    pc_d = pc_q + (prefix_i ? 16'h2 : 16'h1);
                    if (dec.op == OP_TRAP) state_d = ST_PUSH;
                    else state_d = first_step(dec.mode);
                end else if (load_i) begin
                    a_d = load_acc_i;
                    x_d = load_idx_lo_i;
                    h_d = load_idx_hi_i;
                    sp_d = load_sp_i;
                    pc_d = load_pc_i;
                    ccr_d = load_flags_i;
                end
            end
            ST_OFS_HI: begin
                hi_d = mem_rdata_i;
                pc_d = pc_q + 16'h1;
                state_d = ST_OFS_LO;
            end
            ST_OFS_LO: begin
                lo_d = mem_rdata_i;
                pc_d = pc_q + 16'h1;
                if (mode_q == MD_DIRREL) state_d = ST_REL;
                else if (mode_q == MD_REL) state_d = ST_EXEC;
                else state_d = ST_READ;
            end
            ST_REL: begin
                rel_d = mem_rdata_i;
                pc_d = pc_q + 16'h1;
                state_d = ST_READ;
            end
            ST_READ: begin
                data_d = mem_rdata_i;
                if (mode_q == MD_IMM) pc_d = pc_q + 16'h1;
                if (mode_q == MD_IXP || mode_q == MD_IX1P ||
                    (op_q == OP_MOVE && mv_q == MV_IXPD)) begin
                    {h_d, x_d} = hx_d;
                end
                if (op_q != OP_MOVE) state_d = ST_EXEC;
                else if (mv_q == MV_DIXP) state_d = ST_WRITE;
                else state_d = ST_DST;
            end
            ST_DST: begin
                dst_d = mem_rdata_i;
                pc_d = pc_q + 16'h1;
                state_d = ST_WRITE;
            end
            ST_WRITE: begin
                if (mv_q == MV_DIXP) {h_d, x_d} = hx_d;
                state_d = ST_EXEC;
            end
            ST_PUSH: begin
                sp_d = sp_q - 16'h1;
                push_d = push_q + 3'h1;
                if (push_q == `COD_PUSH_LAST) state_d = ST_VEC_HI;
            end
            ST_VEC_HI: begin
                vhi_d = mem_rdata_i;
                ccr_d[`COD_FLG_I] = 1'b1;
                state_d = ST_VEC_LO;
            end
            ST_VEC_LO: begin
                pc_d = {vhi_q, mem_rdata_i};
                state_d = ST_EXEC;
            end
            ST_EXEC: begin
                if (last) begin
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                    bad_d = (op_q == OP_BAD);
                    opnd_d = data_q;
                    case (op_q)
                        OP_TEST: begin
                            opnd_d = tst_v;
                            ccr_d[`COD_FLG_N] = tst_v[7];
                            ccr_d[`COD_FLG_Z] = (tst_v == 8'h00);
                            ccr_d[`COD_FLG_V] = 1'b0;
                        end
                        OP_XFER: begin
                            case (opc_q)
                                `COD_OP_HX2SP: sp_d = hx - 16'h1;
                                `COD_OP_SP2HX: {h_d, x_d} = sp_q + 16'h1;
                                `COD_OP_A2F: ccr_d = a_q;
                                `COD_OP_F2A: a_d = ccr_q;
                                `COD_OP_A2X: x_d = a_q;
                                `COD_OP_X2A: a_d = x_q;
                                default: a_d = a_q;
                            endcase
                        end
                        default: opnd_d = data_q;
                    endcase
                end
            end
            default: state_d = ST_IDLE;
        endcase
        busy_d = (state_d != ST_IDLE);
        cyc_d = (state_q == ST_IDLE || state_d == ST_IDLE) ? 4'h0 : cyc_q + 4'h1;
    end

    // ----------------------------------------
    // Bus address for the step being entered
    // ----------------------------------------
    assign eai.mode = mode_d;
    assign eai.hx = hx;
    assign eai.sp = sp_q;
    assign eai.pc = pc_d;
    assign eai.ofs = {hi_d, lo_d};
    assign eai.rel = (mode_q == MD_REL) ? lo_q : rel_q;

    always_comb begin
        addr_d = addr_q;
        wdata_d = wdata_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        ea_d = ea_q;
        tgt_d = (state_q == ST_EXEC && last) ? eai.target : tgt_q;
        case (state_d)
            ST_OFS_HI, ST_OFS_LO, ST_REL, ST_DST: begin
                addr_d = pc_d;
                rd_d = 1'b1;
            end
            ST_READ: begin
                addr_d = eai.ea;
                ea_d = eai.ea;
                rd_d = 1'b1;
            end
            ST_WRITE: begin
                addr_d = (mv_d == MV_DIXP) ? hx : {`COD_PAGE0, dst_d};
                wdata_d = data_d;
                wr_d = 1'b1;
            end
            ST_PUSH: begin
                addr_d = sp_d;
                wr_d = 1'b1;
                case (push_d)
                    3'h0: wdata_d = pc_d[7:0];
                    3'h1: wdata_d = pc_d[15:8];
                    3'h2: wdata_d = x_d;
                    3'h3: wdata_d = a_d;
                    default: wdata_d = ccr_d;
                endcase
            end
            ST_VEC_HI: begin
                addr_d = VEC_ADDR;
                rd_d = 1'b1;
            end
            ST_VEC_LO: begin
                addr_d = VEC_ADDR + 16'h1;
                rd_d = 1'b1;
            end
            default: addr_d = addr_q;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            op_q <= OP_BAD;
            mode_q <= MD_INH;
            mv_q <= MV_DD;
            {opc_q, hi_q, lo_q, rel_q, dst_q, data_q, vhi_q} <= '0;
            {cyc_q, total_q, push_q} <= '0;
            {a_q, x_q, h_q, opnd_q} <= '0;
            ccr_q <= `COD_RST_FLAGS;
            sp_q <= `COD_RST_SP;
            pc_q <= 16'h0000;
            {busy_q, done_q, bad_q, rd_q, wr_q} <= '0;
            {addr_q, ea_q, tgt_q} <= '0;
            wdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            mode_q <= mode_d;
            mv_q <= mv_d;
            {opc_q, hi_q, lo_q, rel_q, dst_q, data_q, vhi_q} <=
                {opc_d, hi_d, lo_d, rel_d, dst_d, data_d, vhi_d};
            {cyc_q, total_q, push_q} <= {cyc_d, total_d, push_d};
            {a_q, x_q, h_q, opnd_q, ccr_q} <= {a_d, x_d, h_d, opnd_d, ccr_d};
            sp_q <= sp_d;
            pc_q <= pc_d;
            {busy_q, done_q, bad_q, rd_q, wr_q} <= {busy_d, done_d, bad_d, rd_d, wr_d};
            {addr_q, ea_q, tgt_q} <= {addr_d, ea_d, tgt_d};
            wdata_q <= wdata_d;
        end
    end

    assign {mem_addr_o, mem_rd_o, mem_wr_o, mem_wdata_o} = {addr_q, rd_q, wr_q, wdata_q};
    assign {acc_o, idx_lo_o, idx_hi_o, sp_o, pc_o, flags_o} = {a_q, x_q, h_q, sp_q, pc_q, ccr_q};
    assign {busy_o, done_o, bad_op_o, operand_o} = {busy_q, done_q, bad_q, opnd_q};
    assign {ea_o, target_o} = {ea_q, tgt_q};

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    wire [7:0] ret_lo = pc_q[7:0] + 8'h1;
    wire go_trap = take && dec.op == OP_TRAP;
    wire go_test = take && dec.op == OP_TEST;
    wire go_ext = take && dec.op == OP_FETCH && dec.mode == MD_EXT;
    wire go_ixp = take && dec.op == OP_FETCH && dec.mode == MD_IXP;
    wire go_xfer = take && dec.op == OP_XFER;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_TRAP_LEN: assert property (go_trap |=> busy_o [*8] ##1 busy_o
        ##1 (done_o && !busy_o)) else $error("trap length wrong");
    AST_TRAP_PUSH0: assert property (go_trap |=> mem_wr_o && mem_addr_o == $past(sp_o)
        && mem_wdata_o == $past(ret_lo)) else $error("first trap push wrong");
    AST_TRAP_END: assert property (go_trap |-> ##10 (flags_o[`COD_FLG_I]
        && sp_o == $past(sp_o, 10) - 16'h5)) else $error("trap end state wrong");
    AST_TST_FLAGS: assert property (done_o && op_q == OP_TEST |-> !flags_o[`COD_FLG_V]
        && flags_o[`COD_FLG_Z] == (operand_o == 8'h00) && flags_o[`COD_FLG_N] == operand_o[7])
        else $error("test flags wrong");
    AST_TST_NOWR: assert property (busy_o && op_q == OP_TEST |-> !mem_wr_o)
        else $error("test wrote memory");
    AST_TST_INH: assert property (go_test && dec.mode == MD_INH |=> busy_o ##1 done_o)
        else $error("inherent test length wrong");
    AST_TST_SP1: assert property (go_test && dec.mode == MD_SP1 |=> busy_o [*4] ##1 done_o)
        else $error("stack test length wrong");
    AST_EXT_ORDER: assert property (go_ext |-> ##3 (mem_rd_o
        && mem_addr_o == {$past(mem_rdata_i, 2), $past(mem_rdata_i, 1)}))
        else $error("extended address order wrong");
    AST_IXP_INC: assert property (go_ixp |-> ##3 ({idx_hi_o, idx_lo_o} == $past(hx, 3) + 16'h1))
        else $error("post increment missing");
    AST_HX2SP: assert property (go_xfer && opcode_i == `COD_OP_HX2SP
        |-> ##3 sp_o == $past(hx, 3) - 16'h1) else $error("index to stack wrong");
    AST_A2F: assert property (go_xfer && opcode_i == `COD_OP_A2F
        |-> ##3 flags_o == $past(acc_o, 3)) else $error("acc to flags wrong");
    AST_A2X: assert property (go_xfer && opcode_i == `COD_OP_A2X
        |-> ##2 (idx_lo_o == $past(acc_o, 2) && flags_o == $past(flags_o, 2)))
        else $error("acc to index wrong");

    COV_TRAP: cover property (go_trap ##10 done_o);
    COV_TST_SP1: cover property (go_test && dec.mode == MD_SP1);
    COV_MOVE_DD: cover property (take && cmd_i == CMD_MOVE && move_i == MV_DD);
    COV_REL: cover property (take && cmd_i == CMD_FETCH && mode_i == MD_DIRREL);
endmodule

// ===== hdl/cod_ea.sv
`timescale 1ns/1ps
`include "cod_regs.svh"
module cod_ea (
    cod_ea_if.unit u
);
    import cod_pkg::*;

    // ----------------------------------------
    // Effective address per addressing mode
    // ----------------------------------------
    always_comb begin
        case (u.mode)
            MD_DIR, MD_DIRREL: u.ea = {`COD_PAGE0, u.ofs[7:0]};
            MD_EXT: u.ea = u.ofs;
            MD_IX, MD_IXP: u.ea = u.hx;
            MD_IX1, MD_IX1P: u.ea = u.hx + {8'h00, u.ofs[7:0]};
            MD_IX2: u.ea = u.hx + u.ofs;
            MD_SP1: u.ea = u.sp + {8'h00, u.ofs[7:0]};
            MD_SP2: u.ea = u.sp + u.ofs;
            default: u.ea = u.pc;
        endcase
    end

    // Offset is signed; pc already points past the offset byte
    assign u.target = u.pc + {{8{u.rel[7]}}, u.rel};
endmodule

// ===== hdl/cod_ea_if.sv
`timescale 1ns/1ps
interface cod_ea_if;
    cod_pkg::cod_mode_t mode;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ofs;
    logic [7:0] rel;
    logic [15:0] ea;
    logic [15:0] target;
    modport core (output mode, hx, sp, pc, ofs, rel, input ea, target);
    modport unit (input mode, hx, sp, pc, ofs, rel, output ea, target);
endinterface

// ===== hdl/cod_pkg.sv
package cod_pkg;
    typedef enum logic [1:0] {CMD_EXEC, CMD_FETCH, CMD_MOVE} cod_cmd_t;
    typedef enum logic [3:0] {
        MD_INH, MD_IMM, MD_DIR, MD_EXT, MD_IX, MD_IX1, MD_IX2,
        MD_SP1, MD_SP2, MD_IXP, MD_IX1P, MD_REL, MD_DIRREL
    } cod_mode_t;
    typedef enum logic [1:0] {MV_DD, MV_IMD, MV_DIXP, MV_IXPD} cod_move_t;
    typedef enum logic [2:0] {
        OP_BAD, OP_TRAP, OP_TEST, OP_XFER, OP_FETCH, OP_MOVE
    } cod_op_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_OFS_HI, ST_OFS_LO, ST_REL, ST_READ, ST_DST,
        ST_WRITE, ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_EXEC
    } cod_state_t;
    typedef struct packed {
        cod_op_t op;
        cod_mode_t mode;
        logic [3:0] cycles;
    } cod_dec_t;
endpackage

// ===== hdl/cod_regs.svh
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define COD_FLG_V 7
`define COD_FLG_H 4
`define COD_FLG_I 3
`define COD_FLG_N 2
`define COD_FLG_Z 1
`define COD_FLG_C 0

// ----------------------------------------
// Opcodes handled here
// ----------------------------------------
`define COD_OP_TRAP 8'h83
`define COD_OP_TST_DIR 8'h3D
`define COD_OP_TST_A 8'h4D
`define COD_OP_TST_X 8'h5D
`define COD_OP_TST_IX1 8'h6D
`define COD_OP_TST_IX 8'h7D
`define COD_OP_HX2SP 8'h94
`define COD_OP_SP2HX 8'h95
`define COD_OP_A2F 8'h84
`define COD_OP_F2A 8'h85
`define COD_OP_A2X 8'h97
`define COD_OP_X2A 8'h9F

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define COD_CYC_TRAP 4'h9
`define COD_CYC_TST_DIR 4'h3
`define COD_CYC_TST_INH 4'h1
`define COD_CYC_TST_IX1 4'h3
`define COD_CYC_TST_IX 4'h2
`define COD_CYC_TST_SP1 4'h4
`define COD_CYC_XFER2 4'h2
`define COD_CYC_XFER1 4'h1
`define COD_CYC_FREE 4'h0

// ----------------------------------------
// Reset values and fixed addresses
// ----------------------------------------
`define COD_TRAP_VEC 16'hFFF0
`define COD_RST_SP 16'h00FF
`define COD_RST_FLAGS 8'h08
`define COD_PAGE0 8'h00
`define COD_PUSH_LAST 3'h4

`endif
